// ===== design/css_defs.svh
/*
 Constants of the card session sequencer: timing counts, register
 indexes, field positions and reset values.
 Assumes a 25 MHz system clock; included by bare name.
*/
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH

// Timing: clock period and sequencer tick in ns
`define CSS_CLK_NS 40
`define CSS_TICK_NS 25000
`define CSS_HALF_CYC ((`CSS_TICK_NS / 2) / `CSS_CLK_NS)
`define CSS_WAKE_CYC 1536

// Sequencer steps, counted in half ticks
`define CSS_ACT_VCC 3
`define CSS_ACT_IO 7
`define CSS_ACT_CLK 8
`define CSS_DE_CLK 1
`define CSS_DE_IO 2
`define CSS_DE_VCC 3
`define CSS_DE_OFF 7

// Register indexes; byte address is index times four
`define CSS_IDX_UART_CTRL 8'h03
`define CSS_IDX_POWER_CTRL 8'h07
`define CSS_IDX_MIXED_STATUS 8'h0c
`define CSS_IDX_HW_STATUS 8'h0f
`define CSS_IDX_CPU_POWER 8'h10

// Field positions
`define CSS_PC_ACTIVATE 0
`define CSS_PC_VOLT3 1
`define CSS_PC_RSTCTRL 2
`define CSS_PC_LOWVOLT 3
`define CSS_UC_RX_WAKE 4
`define CSS_UC_EXT_WAKE 7
`define CSS_MS_PRESENT 2
`define CSS_HS_SHUTDOWN 7
`define CSS_HS_OVERCUR 5
`define CSS_HS_SUPLOW 4
`define CSS_HS_PRESCHG 2
`define CSS_HS_OVERTEMP 0
`define CSS_CP_STOP_HIGH 0
`define CSS_CP_POWER_DOWN 1
`define CSS_CP_EXT_IRQ_EN 2

// Reset values and AXI4-Lite response codes
`define CSS_RST_CONTACTS 8'h80
`define CSS_RST_PINS 11'h000
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_SLVERR 2'h2

// Analogue trip points, realised by comparators outside this logic
`define CSS_RST_ILIM_MA 20
`define CSS_TEMP_LIMIT_C 150
`define CSS_DCIN_SWITCH_MV 3500

`endif

// ===== design/css_pkg.sv
/*
 Types of the card session sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package css_pkg;

	// Sequencer states
	typedef enum logic [1:0] {st_idle, st_act, st_on, st_deact} css_state_t;

	// Converter operating mode
	typedef enum logic [1:0] {cm_follower, cm_doubler, cm_tripler} css_conv_t;

	// Card contact controls, grounded is the most significant bit
	typedef struct packed {
		logic grounded;
		logic conv_run;
		logic vcc_on;
		logic io_high;
		logic clk_on;
		logic rst_en;
		logic vsel_3v;
		logic vsel_1v8;
	} css_contacts_t;

	// Asynchronous pin inputs
	typedef struct packed {
		logic card_detect;
		logic alarm;
		logic reset_pin;
		logic shutdown_in_n;
		logic vcc_oc;
		logic rst_oc;
		logic overtemp;
		logic dcin_high;
		logic rx_in;
		logic ext_irq_n;
		logic card_clk_src;
	} css_pins_t;

endpackage

// ===== design/css_sync.sv
/*
 Two-stage synchroniser for all asynchronous pins of the sequencer.
 Assumes pins are quasi-static relative to the 25 MHz clock.
*/
`timescale 1ns/1ns
`include "css_defs.svh"
module css_sync
(
	input wire logic clk,
	input wire logic srst,
	input css_pkg::css_pins_t d,
	output css_pkg::css_pins_t q
);
	css_pkg::css_pins_t meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta <= `CSS_RST_PINS;
			q <= `CSS_RST_PINS;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ===== design/css_top.sv
/*
 Card session sequencer: activation, deactivation, emergency stop,
 status flags, supply and shutdown resets, wake-up, AXI4-Lite registers.
 Assumes analogue comparators drive the pin inputs and a card clock
 source arrives as an asynchronous input.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "css_defs.svh"
module css_top
(
	input wire logic clk,
	input wire logic srst,
	input css_pkg::css_pins_t pins,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output css_pkg::css_contacts_t contacts,
	output logic card_clk,
	output logic card_rst,
	output css_pkg::css_conv_t conv_mode,
	output logic host_irq_n,
	output logic cpu_power_down
);
	// ************************************************************
	// Register decode
	// ************************************************************

	// Returns {hit, index}; shared by the read and write paths
	function automatic logic [8:0] reg_decode(input logic [31:0] a);
		logic [7:0] idx;
		logic hit;
		idx = a[9:2];
		hit = (a[31:10] == 22'h000000) && (idx == `CSS_IDX_UART_CTRL ||
			idx == `CSS_IDX_POWER_CTRL || idx == `CSS_IDX_MIXED_STATUS ||
			idx == `CSS_IDX_HW_STATUS || idx == `CSS_IDX_CPU_POWER);
		return {hit, idx};
	endfunction

	css_pkg::css_pins_t pin_s;
	css_pkg::css_pins_t pin_d;
	css_pkg::css_state_t state;
	css_pkg::css_contacts_t next_contacts;
	logic [8:0] presc;
	logic [3:0] step;
	logic [10:0] wake_cnt;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] next_rdata;
	logic [8:0] wr_dec;
	logic [8:0] rd_dec;
	logic session_activate, volt_select, card_reset_ctrl, low_volt_select;
	logic rx_wake_en, ext_wake_en, clk_stop_high, ext_irq_enable;
	logic card_present_flag, presence_change_flag, overcurrent_flag;
	logic overtemp_flag, shutdown_flag, supply_low_flag;
	logic waking, sd_low_seen;
	logic half_tick, chip_rst, emerg, act_ok, oc, hs_rd, wr_go, wr_en;
	logic sd_fall, sd_rise, rx_fall, ext_fall, wake_evt;

	// Every pin passes two flops before use
	css_sync u_sync
	(
		.clk(clk),
		.srst(srst),
		.d(pins),
		.q(pin_s)
	);

	// Edge history of synchronised pins
	always_ff @(posedge clk)
	begin
		if (srst)
			pin_d <= `CSS_RST_PINS;
		else
			pin_d <= pin_s;
	end

	// ************************************************************
	// Reset and event conditions
	// ************************************************************

	// Alarm and reset pin reset the chip only once the card is idle
	assign sd_fall = pin_d.shutdown_in_n && !pin_s.shutdown_in_n;
	assign sd_rise = sd_low_seen && !pin_d.shutdown_in_n && pin_s.shutdown_in_n;
	assign chip_rst = srst || sd_rise ||
		((pin_s.alarm || pin_s.reset_pin) && state == css_pkg::st_idle);
	assign oc = pin_s.vcc_oc || pin_s.rst_oc;
	assign emerg = !pin_s.card_detect || oc || pin_s.overtemp ||
		pin_s.alarm || pin_s.reset_pin;
	assign act_ok = pin_s.card_detect && !pin_s.alarm && !emerg;
	assign half_tick = (presc == 9'(`CSS_HALF_CYC - 1));
	assign rx_fall = pin_d.rx_in && !pin_s.rx_in;
	assign ext_fall = pin_d.ext_irq_n && !pin_s.ext_irq_n;
	assign wake_evt = (card_present_flag != pin_s.card_detect) || oc ||
		pin_s.reset_pin || (ext_wake_en && ext_irq_enable &&
		(ext_fall || (rx_fall && rx_wake_en)));

	// Remember that shutdown was entered so exit is a real edge
	always_ff @(posedge clk)
	begin
		if (chip_rst)
			sd_low_seen <= 1'b0;
		else if (sd_fall)
			sd_low_seen <= 1'b1;
	end

	// ************************************************************
	// Sequencer
	// ************************************************************

	// Half-tick divider, held in idle and on, restarted on leaving act, so that
	// both sequences count whole half ticks from their first contact change
	always_ff @(posedge clk)
	begin
		if (chip_rst || half_tick || state == css_pkg::st_idle || state == css_pkg::st_on ||
			(state == css_pkg::st_act && (emerg || !session_activate)))
			presc <= 9'h000;
		else
			presc <= presc + 9'h001;
	end

	// Session state machine
	always_ff @(posedge clk)
	begin
		if (chip_rst)
		begin
			state <= css_pkg::st_idle;
			step <= 4'h0;
		end
		else
		begin
			unique case (state)
				css_pkg::st_idle:
					if (session_activate && act_ok)
					begin
						state <= css_pkg::st_act;
						step <= 4'h0;
					end
				css_pkg::st_act, css_pkg::st_on:
					if (emerg || !session_activate)
					begin
						state <= css_pkg::st_deact;
						step <= 4'h0;
					end
					else if (state == css_pkg::st_act && half_tick)
					begin
						if (step == 4'(`CSS_ACT_CLK - 1))
							state <= css_pkg::st_on;
						step <= step + 4'h1;
					end
				css_pkg::st_deact:
					if (half_tick)
					begin
						if (step == 4'(`CSS_DE_OFF - 1))
							state <= css_pkg::st_idle;
						step <= step + 4'h1;
					end
			endcase
		end
	end

	// Contact controls from state and step
	always_comb
	begin
		next_contacts = `CSS_RST_CONTACTS;
		next_contacts.vsel_3v = volt_select;
		next_contacts.vsel_1v8 = low_volt_select;
		unique case (state)
			css_pkg::st_idle:
				next_contacts.grounded = 1'b1;
			css_pkg::st_act:
			begin
				next_contacts.grounded = 1'b0;
				next_contacts.conv_run = 1'b1;
				next_contacts.vcc_on = step >= 4'(`CSS_ACT_VCC);
				next_contacts.io_high = step >= 4'(`CSS_ACT_IO);
			end
			css_pkg::st_on:
			begin
				next_contacts.grounded = 1'b0;
				next_contacts.conv_run = 1'b1;
				next_contacts.vcc_on = 1'b1;
				next_contacts.io_high = 1'b1;
				next_contacts.clk_on = 1'b1;
				next_contacts.rst_en = 1'b1;
			end
			css_pkg::st_deact:
			begin
				next_contacts.grounded = 1'b0;
				next_contacts.conv_run = 1'b1;
				next_contacts.vcc_on = step < 4'(`CSS_DE_VCC);
				next_contacts.io_high = step < 4'(`CSS_DE_IO);
				next_contacts.clk_on = step < 4'(`CSS_DE_CLK);
			end
		endcase
	end

	// Contact outputs; sleep parks the clock at the chosen level
	always_ff @(posedge clk)
	begin
		if (chip_rst)
		begin
			contacts <= `CSS_RST_CONTACTS;
			card_clk <= 1'b0;
			card_rst <= 1'b0;
		end
		else
		begin
			contacts <= next_contacts;
			if (!next_contacts.clk_on)
				card_clk <= 1'b0;
			else if (cpu_power_down)
				card_clk <= clk_stop_high;
			else
				card_clk <= pin_s.card_clk_src;
			card_rst <= next_contacts.rst_en && card_reset_ctrl;
		end
	end

	// Converter mode from input level and target voltage
	always_ff @(posedge clk)
	begin
		if (chip_rst)
			conv_mode <= css_pkg::cm_follower;
		else if (low_volt_select || (pin_s.dcin_high && volt_select))
			conv_mode <= css_pkg::cm_follower;
		else if (pin_s.dcin_high || volt_select)
			conv_mode <= css_pkg::cm_doubler;
		else
			conv_mode <= css_pkg::cm_tripler;
	end

	// ************************************************************
	// Status flags and interrupt
	// ************************************************************

	// Hardware sets win over the clear-on-read of the status register
	always_ff @(posedge clk)
	begin
		if (chip_rst)
		begin
			card_present_flag <= 1'b0;
			presence_change_flag <= 1'b0;
			overcurrent_flag <= 1'b0;
			overtemp_flag <= 1'b0;
			shutdown_flag <= 1'b0;
		end
		else
		begin
			card_present_flag <= pin_s.card_detect;
			if (card_present_flag != pin_s.card_detect)
				presence_change_flag <= 1'b1;
			else if (hs_rd)
				presence_change_flag <= 1'b0;
			if (oc)
				overcurrent_flag <= 1'b1;
			else if (hs_rd)
				overcurrent_flag <= 1'b0;
			if (pin_s.overtemp)
				overtemp_flag <= 1'b1;
			else if (hs_rd)
				overtemp_flag <= 1'b0;
			if (sd_fall)
				shutdown_flag <= 1'b1;
			else if (hs_rd)
				shutdown_flag <= 1'b0;
		end
	end

	// Supply-low is set by every internal reset and needs an alarm-free read to clear
	always_ff @(posedge clk)
	begin
		if (chip_rst)
			supply_low_flag <= 1'b1;
		else if (hs_rd && !pin_s.alarm)
			supply_low_flag <= 1'b0;
	end

	// Interrupt low during reset and while any event flag other than supply-low is pending
	always_ff @(posedge clk)
	begin
		if (chip_rst)
			host_irq_n <= 1'b0;
		else
			host_irq_n <= !(presence_change_flag || overcurrent_flag ||
				overtemp_flag || shutdown_flag);
	end

	// ************************************************************
	// Power-down and wake-up
	// ************************************************************

	// Waking holds power-down for the oscillator restart time
	always_ff @(posedge clk)
	begin
		if (chip_rst)
		begin
			cpu_power_down <= 1'b0;
			waking <= 1'b0;
			wake_cnt <= 11'h000;
		end
		else if (waking)
		begin
			if (wake_cnt == 11'(`CSS_WAKE_CYC - 1))
			begin
				cpu_power_down <= 1'b0;
				waking <= 1'b0;
				wake_cnt <= 11'h000;
			end
			else
				wake_cnt <= wake_cnt + 11'h001;
		end
		else if (cpu_power_down && wake_evt)
			waking <= 1'b1;
		else if (wr_en && wr_dec[7:0] == `CSS_IDX_CPU_POWER)
			cpu_power_down <= w_data[`CSS_CP_POWER_DOWN];
	end

	// ************************************************************
	// Registers and AXI4-Lite slave
	// ************************************************************

	assign wr_dec = reg_decode(aw_addr);
	assign rd_dec = reg_decode(s_axi_araddr);
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_en = wr_go && wr_dec[8] && w_strb[0];
	assign hs_rd = s_axi_arvalid && s_axi_arready && rd_dec[8] &&
		rd_dec[7:0] == `CSS_IDX_HW_STATUS;

	// Software registers; emergency clear beats a write for safety
	always_ff @(posedge clk)
	begin
		if (chip_rst)
		begin
			session_activate <= 1'b0;
			volt_select <= 1'b0;
			card_reset_ctrl <= 1'b0;
			low_volt_select <= 1'b0;
			rx_wake_en <= 1'b0;
			ext_wake_en <= 1'b0;
			clk_stop_high <= 1'b0;
			ext_irq_enable <= 1'b0;
		end
		else
		begin
			if (emerg)
				session_activate <= 1'b0;
			else if (wr_en && wr_dec[7:0] == `CSS_IDX_POWER_CTRL)
				session_activate <= w_data[`CSS_PC_ACTIVATE] && act_ok;
			if (wr_en && wr_dec[7:0] == `CSS_IDX_POWER_CTRL)
			begin
				volt_select <= w_data[`CSS_PC_VOLT3];
				card_reset_ctrl <= w_data[`CSS_PC_RSTCTRL];
				low_volt_select <= w_data[`CSS_PC_LOWVOLT];
			end
			if (wr_en && wr_dec[7:0] == `CSS_IDX_UART_CTRL)
			begin
				rx_wake_en <= w_data[`CSS_UC_RX_WAKE];
				ext_wake_en <= w_data[`CSS_UC_EXT_WAKE];
			end
			if (wr_en && wr_dec[7:0] == `CSS_IDX_CPU_POWER)
			begin
				clk_stop_high <= w_data[`CSS_CP_STOP_HIGH];
				ext_irq_enable <= w_data[`CSS_CP_EXT_IRQ_EN];
			end
		end
	end

	// Read mux; unmapped indexes return zero; the data ignores address bits above 9, only the response checks them
	always_comb
	begin
		next_rdata = 32'h00000000;
		unique case (rd_dec[7:0])
			`CSS_IDX_POWER_CTRL:
				next_rdata[3:0] = {low_volt_select, card_reset_ctrl,
					volt_select, session_activate};
			`CSS_IDX_UART_CTRL:
			begin
				next_rdata[`CSS_UC_RX_WAKE] = rx_wake_en;
				next_rdata[`CSS_UC_EXT_WAKE] = ext_wake_en;
			end
			`CSS_IDX_MIXED_STATUS:
				next_rdata[`CSS_MS_PRESENT] = card_present_flag;
			`CSS_IDX_HW_STATUS:
			begin
				next_rdata[`CSS_HS_SHUTDOWN] = shutdown_flag;
				next_rdata[`CSS_HS_OVERCUR] = overcurrent_flag;
				next_rdata[`CSS_HS_SUPLOW] = supply_low_flag;
				next_rdata[`CSS_HS_PRESCHG] = presence_change_flag;
				next_rdata[`CSS_HS_OVERTEMP] = overtemp_flag;
			end
			`CSS_IDX_CPU_POWER:
				next_rdata[2:0] = {ext_irq_enable, cpu_power_down, clk_stop_high};
			default:
				next_rdata = 32'h00000000;
		endcase
	end

	// Write channels: address and data taken independently
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CSS_RESP_OKAY;
			aw_addr <= 32'h00000000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_dec[8] ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read channel: data one cycle after the address is taken
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CSS_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rd_dec[8] ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************

	localparam int VCC_DLY = `CSS_ACT_VCC * `CSS_HALF_CYC;
	localparam int CLK_DLY = `CSS_ACT_CLK * `CSS_HALF_CYC;
	localparam int DE_VCC_AGE = `CSS_DE_VCC * `CSS_HALF_CYC + 1;
	logic [11:0] act_age;
	logic [11:0] deact_age;

	// Cycle counters since converter start and since deactivation began
	always_ff @(posedge clk)
	begin
		act_age <= contacts.conv_run ? act_age + 12'h001 : 12'h000;
		deact_age <= (state == css_pkg::st_deact) ? deact_age + 12'h001 : 12'h000;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	chk_act_gate: assert property (
		(state == css_pkg::st_idle && !act_ok && !chip_rst) |=> state == css_pkg::st_idle)
		else $error("activation started without card or with alarm");
	chk_idle_contacts: assert property (
		(state == css_pkg::st_idle) |=> contacts.grounded && !contacts.conv_run && !card_rst)
		else $error("idle contacts not grounded");
	chk_act_order: assert property (
		$rose(contacts.io_high) |-> contacts.vcc_on && contacts.conv_run && !contacts.clk_on)
		else $error("activation order broken");
	chk_vcc_delay: assert property (
		$rose(contacts.vcc_on) |-> act_age == 12'(VCC_DLY))
		else $error("supply ramp not at 1.5T");
	chk_clk_delay: assert property (
		$rose(contacts.clk_on) |-> act_age == 12'(CLK_DLY))
		else $error("clock enable not at 4T");
	chk_rst_copy: assert property (
		(state == css_pkg::st_on && !chip_rst) |=> card_rst == $past(card_reset_ctrl))
		else $error("card reset does not follow control bit");
	chk_deact_vcc: assert property (
		($fell(contacts.vcc_on) && !$past(chip_rst)) |-> !card_rst && !contacts.io_high &&
			deact_age == 12'(DE_VCC_AGE))
		else $error("supply fall out of order or time");
	chk_auto_clear: assert property (
		(emerg && !chip_rst) |=> !session_activate)
		else $error("activate not cleared on emergency");
	chk_por_irq: assert property (
		chip_rst |=> !host_irq_n && supply_low_flag)
		else $error("reset did not pull irq or set supply low");
	chk_wake_wait: assert property (
		($fell(cpu_power_down) && !$past(chip_rst)) |-> $past(waking) && wake_cnt == 11'h000)
		else $error("power-down left without wake wait");
	chk_conv_mode: assert property (
		(low_volt_select && !chip_rst) |=> conv_mode == css_pkg::cm_follower)
		else $error("1.8 V not in follower mode");
endmodule

// ===== verif/css_card.sv
/*
 Card model on the contact side of the session sequencer.
 Assumes contact controls and the card clock come from the sequencer.
*/
`timescale 1ns/1ns
module css_card
(
	input wire logic clk,
	input css_pkg::css_contacts_t contacts,
	input wire logic card_clk,
	input wire logic inserted,
	input wire logic fault,
	output logic card_detect,
	output logic vcc_oc,
	output logic rx_in,
	output int clk_edges
);
	logic last_clk = 1'b0;
	int edges = 0;
	// Detect switch follows insertion; a short only draws current when powered
	assign card_detect = inserted;
	assign vcc_oc = fault & contacts.vcc_on;
	assign rx_in = 1'b1; // Line idles high, card sends nothing
	assign clk_edges = edges;
	// Count card clock edges as the system clock sees them
	always @(posedge clk)
	begin
		last_clk <= card_clk;
		if (card_clk !== last_clk)
			edges <= edges + 1;
	end
endmodule

// ===== verif/css_top_tb.sv
/*
 Self-checking bench of the card session sequencer.
 Assumes a 25 MHz clock and AXI4-Lite byte addresses of index times four.
*/
`timescale 1ns/1ns
module css_top_tb;
	logic clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
	logic bvalid, arready, rvalid, card_clk, card_rst, host_irq_n, pdn;
	logic [31:0] awaddr, wdata, araddr, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic alarm, rpin, sd_n, dcin, cks, ins, flt, cd, voc, rx, v;
	css_pkg::css_pins_t pins;
	css_pkg::css_contacts_t contacts;
	css_pkg::css_conv_t conv_mode;
	int failures, checks_done, cyc, e0, k;
	int ad[4] = '{-1, 936, 1248, 312};
	logic [5:0] ae[4] = '{6'h10, 6'h18, 6'h1c, 6'h1f};
	int dd[5] = '{-1, 312, 312, 312, 1248};
	logic [5:0] de[5] = '{6'h1e, 6'h1c, 6'h18, 6'h10, 6'h20};
	// Overtemp, reset-pin overcurrent and external irq are held quiet
	assign pins = {cd, alarm, rpin, sd_n, voc, 1'b0, 1'b0, dcin, rx, 1'b1, cks};
	css_top uut (.clk(clk), .srst(srst), .pins(pins), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .contacts(contacts), .card_clk(card_clk),
		.card_rst(card_rst), .conv_mode(conv_mode), .host_irq_n(host_irq_n),
		.cpu_power_down(pdn));
	css_card card (.clk(clk), .contacts(contacts), .card_clk(card_clk), .inserted(ins),
		.fault(flt), .card_detect(cd), .vcc_oc(voc), .rx_in(rx), .clk_edges(e0));
	// System clock and an unrelated card clock source of 320 ns
	initial
	begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		cks = 0;
		#7;
		forever #160 cks = ~cks;
	end
	// Watchdog: the whole run needs about 17000 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 40000)
		begin
			failures++;
			close_out;
		end
	end
	task chk(input logic [31:0] s, e);
	begin
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	end
	endtask
	// Write holds each channel until its own ready, bready until bvalid
	task wr(input logic [31:0] a, dt);
	begin
		@(posedge clk);
		awaddr <= a;
		wdata <= dt;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (1)
		begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		r = bresp;
	end
	endtask
	task rd(input logic [31:0] a);
	begin
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (1)
		begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		d = rdata;
		r = rresp;
	end
	endtask
	// Count cycles until the sequenced contacts change; voltage selects are left out
	task step(input int dl, input logic [5:0] e);
		int n;
		logic [5:0] p;
	begin
		p = contacts[7:2];
		n = 0;
		while (contacts[7:2] === p && n < 3000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (dl >= 0) chk(n, dl);
		chk(contacts[7:2], e);
	end
	endtask
	task act;
	begin
		wr(32'h1c, 32'h1);
		for (k = 0; k < 4; k++) step(-1, ae[k]);
	end
	endtask
	task close_out;
	begin
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(32'haa668ae6));
		{srst, alarm, sd_n} = 3'b101;
		{awvalid, wvalid, bready, arvalid, rready, rpin, ins, flt, dcin} = 0;
		{awaddr, wdata, araddr} = 0;
		repeat (3) @(posedge clk);
		chk(host_irq_n, 1'b0);
		repeat (3) @(posedge clk);
		srst <= 0;
		repeat (3) @(posedge clk);
		chk(contacts, 8'h80);
		rd(32'h3c);
		chk(d, 32'h10);
		rd(32'h3c);
		chk(d, 32'h0);
		rd(32'h04);
		chk(r, 2'h2);
		wr(32'h04, 32'h0);
		chk(r, 2'h2);
		wr(32'h1c, 32'h1);
		chk(r, 2'h0);
		rd(32'h1c);
		chk(d[0], 1'b0);
		chk(contacts, 8'h80);
		$display("test reset and refusal done");
		ins <= 1;
		repeat (6) @(posedge clk);
		rd(32'h30);
		chk(d[2], 1'b1);
		rd(32'h3c);
		chk(d[2], 1'b1);
		v = $urandom;
		dcin <= $urandom;
		wr(32'h1c, {30'h0, v, 1'b1});
		for (k = 0; k < 4; k++) step(ad[k], ae[k]);
		chk(contacts.vsel_3v, v);
		chk(conv_mode, dcin ? (v ? 0 : 1) : (v ? 1 : 2));
		k = e0;
		repeat (50) @(posedge clk);
		chk(e0 > k, 1'b1);
		wr(32'h1c, {30'h1, v, 1'b1});
		repeat (3) @(posedge clk);
		chk(card_rst, 1'b1);
		wr(32'h1c, {30'h1, v, 1'b0});
		for (k = 0; k < 5; k++) step(dd[k], de[k]);
		chk(card_rst, 1'b0);
		k = e0;
		repeat (50) @(posedge clk);
		chk(e0, k);
		$display("test session done");
		act;
		ins <= 0;
		repeat (8) @(posedge clk);
		chk(host_irq_n, 1'b0);
		rd(32'h1c);
		chk(d[0], 1'b0);
		rd(32'h3c);
		chk(d[2], 1'b1);
		repeat (2600) @(posedge clk);
		chk(contacts, 8'h80);
		ins <= 1;
		repeat (6) @(posedge clk);
		rd(32'h3c);
		act;
		flt <= 1;
		repeat (8) @(posedge clk);
		chk(host_irq_n, 1'b0);
		rd(32'h3c);
		chk(d[5], 1'b1);
		flt <= 0;
		repeat (2600) @(posedge clk);
		chk(contacts, 8'h80);
		$display("test emergency done");
		// Power-down, woken by a card change, leaves only after the wake wait
		wr(32'h40, 32'h2);
		chk(pdn, 1'b1);
		ins <= 0;
		repeat (1000) @(posedge clk);
		chk(pdn, 1'b1);
		repeat (600) @(posedge clk);
		chk(pdn, 1'b0);
		ins <= 1;
		repeat (6) @(posedge clk);
		rd(32'h3c);
		$display("test wake done");
		sd_n <= 0;
		repeat (6) @(posedge clk);
		chk(host_irq_n, 1'b0);
		rd(32'h3c);
		chk(d[7], 1'b1);
		sd_n <= 1;
		repeat (6) @(posedge clk);
		rd(32'h3c);
		chk(d[4], 1'b1);
		alarm <= 1;
		repeat (6) @(posedge clk);
		chk(host_irq_n, 1'b0);
		wr(32'h1c, 32'h1);
		rd(32'h1c);
		chk(d[0], 1'b0);
		alarm <= 0;
		repeat (6) @(posedge clk);
		rd(32'h3c);
		chk(d[4], 1'b1);
		$display("test shutdown and alarm done");
		close_out;
	end
endmodule
